//--- src/smci_pkg.sv
package smci_pkg;
	// Clock and bus timing
	localparam int CLK_HZ     = 100_000_000;
	localparam int SETTLE_MS  = 15;
	localparam int TIMEOUT_MS = 30;
	localparam int SETTLE_CYC = SETTLE_MS * (CLK_HZ / 1000);
	localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int SCL_MAX_HZ = 400_000;
	localparam int SCL_MIN_HZ = 10_000;
	// Quarter of the fastest bus period, rounded up
	localparam int QTR_CYC    = (CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);
	localparam int FILT_CYC   = 3;
	// Byte framing
	localparam logic [3:0] BIT_LAST = 4'h8;
	localparam logic [3:0] BIT_MSB  = 4'h7;
	// Addresses
	localparam logic [6:0] ARA_ADDR   = 7'h0C;
	localparam logic [6:0] FIX_ADDR_A = 7'h4C;
	localparam logic [6:0] FIX_ADDR_B = 7'h4D;

	typedef enum logic [1:0] {
		SMCI_AM_STRAP = 2'h0,
		SMCI_AM_FIX_A = 2'h1,
		SMCI_AM_FIX_B = 2'h2
	} smci_amode_type;

	typedef enum logic [2:0] {
		SMCI_CMD_WRITE = 3'h0,
		SMCI_CMD_READ  = 3'h1,
		SMCI_CMD_SEND  = 3'h2,
		SMCI_CMD_RECV  = 3'h3,
		SMCI_CMD_ARA   = 3'h4
	} smci_cmd_type;

	// Strap code from the resistor decode to client address
	function automatic logic [6:0] smci_strap_addr(input logic [2:0] code);
		case (code)
			3'h0:    smci_strap_addr = 7'h7C;
			3'h1:    smci_strap_addr = 7'h5C;
			3'h2:    smci_strap_addr = 7'h4C;
			3'h3:    smci_strap_addr = 7'h6C;
			3'h4:    smci_strap_addr = 7'h1C;
			default: smci_strap_addr = 7'h3C;
		endcase
	endfunction
endpackage

//--- src/smci_bus_if.sv
`timescale 1ns/1ps
interface smci_bus_if;
	logic scl_host_oe;
	logic sda_host_oe;
	logic sda_dev_oe;
	logic scl;
	logic sda;
	// Open-drain wires with pull-ups
	assign scl = ~scl_host_oe;
	assign sda = ~(sda_host_oe | sda_dev_oe);
	modport dev (input scl, input sda, output sda_dev_oe);
	modport host (input scl, input sda, output scl_host_oe, output sda_host_oe);
endinterface

//--- src/smci_line_sync.sv
`timescale 1ns/1ps
module smci_line_sync #(
	parameter int FILT_LEN = smci_pkg::FILT_CYC
) (
	// Clock, reset, enable
	input  wire logic clk_sys,
	input  wire logic nrst,
	input  wire logic clk_en,
	// Line
	input  wire logic line_in,
	output logic      line_out
);
	import smci_pkg::*;
	localparam int FW = $clog2(FILT_LEN + 1);
	logic          s1_reg;
	logic          s2_reg;
	logic [FW-1:0] cnt_reg;

	// Two-stage synchroniser, idle high
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
		end else if (clk_en) begin
			s1_reg <= line_in;
			s2_reg <= s1_reg;
		end
	end

	// Accept a new level only after it stays stable
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt_reg  <= '0;
			line_out <= 1'b1;
		end else if (clk_en) begin
			if (s2_reg == line_out) begin
				cnt_reg <= '0;
			end else if (cnt_reg == FW'(FILT_LEN - 1)) begin
				cnt_reg  <= '0;
				line_out <= s2_reg;
			end else begin
				cnt_reg <= cnt_reg + 1'b1;
			end
		end
	end
endmodule

//--- src/smci_client.sv
`timescale 1ns/1ps
module smci_client #(
	parameter smci_pkg::smci_amode_type ADDR_MODE = smci_pkg::SMCI_AM_STRAP,
	parameter int SETTLE_CYCLES  = smci_pkg::SETTLE_CYC,
	parameter int TIMEOUT_CYCLES = smci_pkg::TIMEOUT_CYC,
	parameter int FILT_LEN       = smci_pkg::FILT_CYC
) (
	// Clock, reset, enable
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	input  wire logic       clk_en,
	// Two-wire bus
	smci_bus_if.dev         bus,
	// Configuration and strap
	input  wire logic       timeout_en,
	input  wire logic [2:0] strap_code,
	// Register file side
	output logic            reg_wr_stb,
	output logic [7:0]      reg_wr_data,
	output logic [7:0]      reg_ptr,
	input  wire logic [7:0] reg_rd_data,
	// Alert side
	input  wire logic       alert_active,
	output logic            ara_done,
	output logic            bus_ready
);
	import smci_pkg::*;
	localparam int SW = $clog2(SETTLE_CYCLES + 1);
	localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

	typedef enum logic [2:0] {
		D_IDLE  = 3'h0,
		D_ADDR  = 3'h1,
		D_IDX   = 3'h2,
		D_DAT   = 3'h3,
		D_ACK   = 3'h4,
		D_TX    = 3'h5,
		D_TXACK = 3'h6,
		D_WAIT  = 3'h7
	} smci_dstate_type;

	smci_dstate_type state_reg;
	smci_dstate_type nxt_reg;
	logic          scl_f;
	logic          sda_f;
	logic          scl_d_reg;
	logic          sda_d_reg;
	logic          start_det;
	logic          stop_det;
	logic          scl_rise;
	logic          scl_fall;
	logic [SW-1:0] settle_reg;
	logic [TW-1:0] low_cnt_reg;
	logic          tmo_reg;
	logic [2:0]    strap_s1_reg;
	logic [2:0]    strap_s2_reg;
	logic [6:0]    own_addr_reg;
	logic [7:0]    shift_reg;
	logic [3:0]    cnt_reg;
	logic          is_ara_reg;
	logic          sda_oe_reg;

	// Filtered bus lines, fast enough for 400 kHz clocks
	smci_line_sync #(.FILT_LEN(FILT_LEN)) u_scl_sync (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.clk_en   (clk_en),
		.line_in  (bus.scl),
		.line_out (scl_f)
	);
	smci_line_sync #(.FILT_LEN(FILT_LEN)) u_sda_sync (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.clk_en   (clk_en),
		.line_in  (bus.sda),
		.line_out (sda_f)
	);

	// Previous filtered levels for edge detection
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else if (clk_en) begin
			scl_d_reg <= scl_f;
			sda_d_reg <= sda_f;
		end
	end

	// Bus events
	assign start_det = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
	assign stop_det  = scl_f & scl_d_reg & ~sda_d_reg & sda_f;
	// Edges only, so any stretched low phase is accepted while timeout_en is low
	assign scl_rise  = scl_f & ~scl_d_reg;
	assign scl_fall  = ~scl_f & scl_d_reg;

	// Power-up settling and address strap capture
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			settle_reg   <= '0;
			bus_ready    <= 1'b0;
			strap_s1_reg <= 3'h0;
			strap_s2_reg <= 3'h0;
			own_addr_reg <= FIX_ADDR_A;
		end else if (clk_en) begin
			strap_s1_reg <= strap_code;
			strap_s2_reg <= strap_s1_reg;
			if (!bus_ready) begin
				if (settle_reg == SW'(SETTLE_CYCLES - 1)) begin
					bus_ready <= 1'b1;
					// Strap read at the end of settling, pin must be high
					case (ADDR_MODE)
						SMCI_AM_FIX_A: own_addr_reg <= FIX_ADDR_A;
						SMCI_AM_FIX_B: own_addr_reg <= FIX_ADDR_B;
						default:       own_addr_reg <= smci_strap_addr(strap_s2_reg);
					endcase
				end else begin
					settle_reg <= settle_reg + 1'b1;
				end
			end
		end
	end

	// Clock-low timeout, one-cycle pulse
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			low_cnt_reg <= '0;
			tmo_reg     <= 1'b0;
		end else if (clk_en) begin
			tmo_reg <= 1'b0;
			if (scl_f || !timeout_en) begin
				low_cnt_reg <= '0;
			end else if (low_cnt_reg == TW'(TIMEOUT_CYCLES - 1)) begin
				low_cnt_reg <= '0;
				tmo_reg     <= 1'b1;
			end else begin
				low_cnt_reg <= low_cnt_reg + 1'b1;
			end
		end
	end

	// Client protocol engine
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_reg   <= D_IDLE;
			nxt_reg     <= D_IDLE;
			shift_reg   <= 8'h00;
			cnt_reg     <= 4'h0;
			is_ara_reg  <= 1'b0;
			sda_oe_reg  <= 1'b0;
			reg_ptr     <= 8'h00;
			reg_wr_stb  <= 1'b0;
			reg_wr_data <= 8'h00;
			ara_done    <= 1'b0;
		end else if (clk_en) begin
			reg_wr_stb <= 1'b0;
			ara_done   <= 1'b0;
			if (!bus_ready) begin
				state_reg  <= D_IDLE;
				sda_oe_reg <= 1'b0;
			end else if (tmo_reg || stop_det) begin
				state_reg  <= D_IDLE;
				sda_oe_reg <= 1'b0;
			end else if (start_det) begin
				state_reg  <= D_ADDR;
				cnt_reg    <= 4'h0;
				sda_oe_reg <= 1'b0;
			end else begin
				case (state_reg)
					D_ADDR, D_IDX, D_DAT: begin
						if (scl_rise) begin
							shift_reg <= {shift_reg[6:0], sda_f};
							cnt_reg   <= cnt_reg + 1'b1;
						end else if (scl_fall && cnt_reg == BIT_LAST) begin
							// Acknowledge by default, cleared below for refusals
							sda_oe_reg <= 1'b1;
							state_reg  <= D_ACK;
							case (state_reg)
								D_ADDR: begin
									is_ara_reg <= 1'b0;
									if (shift_reg[7:1] == own_addr_reg) begin
										nxt_reg <= shift_reg[0] ? D_TX : D_IDX;
									end else if (shift_reg[7:1] == ARA_ADDR && shift_reg[0]
										&& alert_active) begin
										is_ara_reg <= 1'b1;
										nxt_reg    <= D_TX;
									end else begin
										sda_oe_reg <= 1'b0;
										state_reg  <= D_WAIT;
									end
								end
								D_IDX: begin
									reg_ptr <= shift_reg;
									nxt_reg <= D_DAT;
								end
								default: begin
									reg_wr_stb  <= 1'b1;
									reg_wr_data <= shift_reg;
									// Further bytes are not a valid protocol
									nxt_reg     <= D_WAIT;
								end
							endcase
						end
					end
					D_ACK: begin
						if (scl_fall) begin
							cnt_reg   <= 4'h0;
							state_reg <= nxt_reg;
							if (nxt_reg == D_TX) begin
								// Pointer left as is, repeated reads hit the same register
								shift_reg  <= is_ara_reg ? {own_addr_reg, 1'b0}
									: reg_rd_data;
								sda_oe_reg <= is_ara_reg ? ~own_addr_reg[6] : ~reg_rd_data[7];
							end else begin
								sda_oe_reg <= 1'b0;
							end
						end
					end
					D_TX: begin
						if (scl_rise) begin
							cnt_reg <= cnt_reg + 1'b1;
							// Released a one but the line reads low: lost
							if (is_ara_reg && shift_reg[7] && !sda_f) begin
								sda_oe_reg <= 1'b0;
								state_reg  <= D_WAIT;
							end
						end else if (scl_fall) begin
							if (cnt_reg == BIT_LAST) begin
								sda_oe_reg <= 1'b0;
								state_reg  <= D_TXACK;
								// Full address sent; status flags are not touched here
								ara_done   <= is_ara_reg;
							end else begin
								shift_reg  <= {shift_reg[6:0], 1'b0};
								sda_oe_reg <= ~shift_reg[6];
							end
						end
					end
					D_TXACK: begin
						if (scl_rise) begin
							// High means the host is done reading
							state_reg <= sda_f ? D_WAIT : D_ACK;
							nxt_reg   <= D_TX;
						end
					end
					default: begin
						sda_oe_reg <= 1'b0;
					end
				endcase
			end
		end
	end

	assign bus.sda_dev_oe = sda_oe_reg;
endmodule

//--- src/smci_host.sv
`timescale 1ns/1ps
module smci_host #(
	parameter int QTR_CYCLES    = smci_pkg::QTR_CYC,
	parameter int SETTLE_CYCLES = smci_pkg::SETTLE_CYC,
	parameter int FILT_LEN      = smci_pkg::FILT_CYC
) (
	// Clock, reset, enable
	input  wire logic               clk_sys,
	input  wire logic               nrst,
	input  wire logic               clk_en,
	// Two-wire bus
	smci_bus_if.host                bus,
	// Command
	input  wire logic               cmd_valid,
	input  wire smci_pkg::smci_cmd_type cmd_kind,
	input  wire logic [6:0]         cmd_addr,
	input  wire logic [7:0]         cmd_idx,
	input  wire logic [7:0]         cmd_data,
	output logic                    cmd_ready,
	// Response
	output logic                    rsp_done,
	output logic                    rsp_nack,
	output logic [7:0]              rsp_data
);
	import smci_pkg::*;
	localparam int QW = $clog2(QTR_CYCLES + 1);
	localparam int SW = $clog2(SETTLE_CYCLES + 1);

	typedef enum logic [2:0] {
		OP_START = 3'h0,
		OP_TXAW  = 3'h1,
		OP_TXAR  = 3'h2,
		OP_TXARA = 3'h3,
		OP_TXI   = 3'h4,
		OP_TXD   = 3'h5,
		OP_RX    = 3'h6,
		OP_STOP  = 3'h7
	} smci_op_type;

	// Step program of each protocol
	function automatic smci_op_type op_at(input smci_cmd_type k, input logic [2:0] s);
		smci_op_type p [8];
		p = '{OP_START, OP_TXAW, OP_TXI, OP_STOP, OP_STOP, OP_STOP, OP_STOP, OP_STOP};
		case (k)
			SMCI_CMD_WRITE: p[3] = OP_TXD;
			SMCI_CMD_READ:  p[3:6] = '{OP_START, OP_TXAR, OP_RX, OP_STOP};
			SMCI_CMD_RECV:  p[1:2] = '{OP_TXAR, OP_RX};
			SMCI_CMD_ARA:   p[1:2] = '{OP_TXARA, OP_RX};
			default:        p[3] = OP_STOP;
		endcase
		op_at = p[s];
	endfunction

	smci_cmd_type  kind_reg;
	smci_op_type   op_reg;
	logic          busy_reg;
	logic [2:0]    step_reg;
	logic [1:0]    q_reg;
	logic [3:0]    bit_reg;
	logic [7:0]    sh_reg;
	logic [6:0]    addr_reg;
	logic [7:0]    idx_reg;
	logic [7:0]    data_reg;
	logic [QW-1:0] div_reg;
	logic [SW-1:0] settle_reg;
	logic          scl_f;
	logic          sda_f;
	logic          tick;
	logic          is_tx;
	smci_op_type   op_nx;

	smci_line_sync #(.FILT_LEN(FILT_LEN)) u_scl_sync (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.clk_en   (clk_en),
		.line_in  (bus.scl),
		.line_out (scl_f)
	);
	smci_line_sync #(.FILT_LEN(FILT_LEN)) u_sda_sync (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.clk_en   (clk_en),
		.line_in  (bus.sda),
		.line_out (sda_f)
	);

	// Byte to send for a given step
	function automatic logic [7:0] tx_byte(input smci_op_type o, input logic [6:0] a,
		input logic [7:0] i, input logic [7:0] d);
		case (o)
			OP_TXAW:  tx_byte = {a, 1'b0};
			OP_TXAR:  tx_byte = {a, 1'b1};
			OP_TXARA: tx_byte = {ARA_ADDR, 1'b1};
			OP_TXI:   tx_byte = i;
			OP_TXD:   tx_byte = d;
			default:  tx_byte = 8'hFF;
		endcase
	endfunction

	assign tick  = busy_reg && div_reg == QW'(QTR_CYCLES - 1);
	assign is_tx = op_reg != OP_START && op_reg != OP_RX && op_reg != OP_STOP;
	assign op_nx = op_at(kind_reg, step_reg + 3'h1);

	// Hold off commands while the client settles
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			settle_reg <= '0;
		end else if (clk_en && settle_reg != SW'(SETTLE_CYCLES)) begin
			settle_reg <= settle_reg + 1'b1;
		end
	end

	// Quarter-period divider, at most 400 kHz on the clock
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			div_reg <= '0;
		end else if (clk_en) begin
			div_reg <= (tick || !busy_reg) ? '0 : div_reg + 1'b1;
		end
	end

	// Bit sequencer and pin drive
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			busy_reg        <= 1'b0;
			cmd_ready       <= 1'b0;
			kind_reg        <= SMCI_CMD_WRITE;
			op_reg          <= OP_START;
			step_reg        <= 3'h0;
			q_reg           <= 2'h0;
			bit_reg         <= 4'h0;
			sh_reg          <= 8'hFF;
			addr_reg        <= 7'h00;
			idx_reg         <= 8'h00;
			data_reg        <= 8'h00;
			bus.scl_host_oe <= 1'b0;
			bus.sda_host_oe <= 1'b0;
			rsp_done        <= 1'b0;
			rsp_nack        <= 1'b0;
			rsp_data        <= 8'h00;
		end else if (clk_en) begin
			rsp_done <= 1'b0;
			if (!busy_reg) begin
				cmd_ready <= settle_reg == SW'(SETTLE_CYCLES);
				if (cmd_valid && cmd_ready) begin
					busy_reg  <= 1'b1;
					cmd_ready <= 1'b0;
					kind_reg  <= cmd_kind;
					addr_reg  <= cmd_addr;
					idx_reg   <= cmd_idx;
					data_reg  <= cmd_data;
					op_reg    <= OP_START;
					step_reg  <= 3'h0;
					q_reg     <= 2'h0;
					rsp_nack  <= 1'b0;
				end
			end else if (tick && !(q_reg == 2'h2 && !scl_f)) begin
				// Waiting for the clock to read high honours stretching
				q_reg <= q_reg + 2'h1;
				case (q_reg)
					2'h0: begin
						case (op_reg)
							OP_START: bus.sda_host_oe <= 1'b0;
							OP_STOP:  bus.sda_host_oe <= 1'b1;
							// Data MSB first; ack slot released, read ends in NACK
							default:  bus.sda_host_oe <= is_tx && bit_reg != BIT_LAST
								&& !sh_reg[7];
						endcase
					end
					2'h1: bus.scl_host_oe <= 1'b0;
					2'h2: begin
						case (op_reg)
							OP_START: bus.sda_host_oe <= 1'b1;
							OP_STOP:  bus.sda_host_oe <= 1'b0;
							default: begin
								if (bit_reg != BIT_LAST) begin
									sh_reg <= {sh_reg[6:0], sda_f};
								end else if (is_tx && sda_f) begin
									rsp_nack <= 1'b1;
								end
								if (op_reg == OP_RX && bit_reg == BIT_MSB) begin
									rsp_data <= {sh_reg[6:0], sda_f};
								end
							end
						endcase
					end
					default: begin
						bus.scl_host_oe <= op_reg != OP_STOP;
						bit_reg         <= bit_reg + 4'h1;
						if (op_reg == OP_STOP) begin
							busy_reg <= 1'b0;
							rsp_done <= 1'b1;
						end else if (op_reg == OP_START || bit_reg == BIT_LAST) begin
							bit_reg  <= 4'h0;
							step_reg <= step_reg + 3'h1;
							// Refused byte: go straight to stop
							op_reg   <= (rsp_nack || (is_tx && sda_f)) ? OP_STOP : op_nx;
							sh_reg   <= tx_byte(op_nx, addr_reg, idx_reg, data_reg);
						end
					end
				endcase
			end
		end
	end
endmodule

//--- sim/smci_assertions.sv
`timescale 1ns/1ps
module smci_assertions #(
	parameter int QTR_CYCLES = 63
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Bus enables and wires
	input wire logic scl_host_oe,
	input wire logic sda_host_oe,
	input wire logic sda_dev_oe,
	input wire logic scl,
	input wire logic sda
);
	localparam int START_MAX = QTR_CYCLES + 2;
	localparam int LOW_MAX   = 4 * QTR_CYCLES;
	logic        scl_reg;
	logic        sda_reg;
	logic        stop_reg;
	logic [3:0]  rise_reg;
	logic [15:0] low_reg;
	logic [15:0] high_reg;
	logic        start_w;
	logic        stop_w;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	// Start and stop on the wires
	assign start_w = scl && scl_reg && sda_reg && !sda;
	assign stop_w  = scl && scl_reg && !sda_reg && sda;
	// Wire history, stop flag, clock rises since start
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			scl_reg  <= 1'b1;
			sda_reg  <= 1'b1;
			stop_reg <= 1'b1;
			rise_reg <= 4'h0;
		end else begin
			scl_reg <= scl;
			sda_reg <= sda;
			if (start_w) begin
				stop_reg <= 1'b0;
				rise_reg <= 4'h0;
			end else begin
				if (stop_w) stop_reg <= 1'b1;
				if (scl && !scl_reg && rise_reg != 4'hF) rise_reg <= rise_reg + 4'h1;
			end
		end
	end
	// Length of current low and high clock phases
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			low_reg  <= 16'h0000;
			high_reg <= 16'hFFFF;
		end else if (scl) begin
			low_reg <= 16'h0000;
			if (high_reg != 16'hFFFF) high_reg <= high_reg + 16'h0001;
		end else begin
			high_reg <= 16'h0000;
			low_reg  <= low_reg + 16'h0001;
		end
	end
	// Bus conditions
	sequence s_start; scl && $past(scl) && $fell(sda); endsequence
	sequence s_stop; scl && $past(scl) && $rose(sda); endsequence
	property p_idle_at_release; $rose(nrst) |-> scl && sda; endproperty
	property p_dev_change_low; $changed(sda_dev_oe) |-> !scl && !$past(scl, 3); endproperty
	property p_host_no_skew; $changed(scl_host_oe) |-> $stable(sda_host_oe); endproperty
	property p_start_clock_low; s_start |-> ##[1:START_MAX] !scl; endproperty
	property p_stop_idle; s_stop |-> (scl && sda) [*8]; endproperty
	property p_quiet_after_stop; stop_reg |-> !sda_dev_oe; endproperty
	property p_ack_ninth; sda_dev_oe |-> rise_reg >= 4'h8; endproperty
	property p_low_phase; $rose(scl) |-> low_reg >= QTR_CYCLES && low_reg <= LOW_MAX; endproperty
	property p_high_phase; $fell(scl) |-> high_reg >= QTR_CYCLES; endproperty
	a_idle_at_release: assert property (p_idle_at_release)
		else $error("bus not idle after reset");
	a_dev_change_low: assert property (p_dev_change_low)
		else $error("client data changed outside settled clock low");
	a_host_no_skew: assert property (p_host_no_skew)
		else $error("host moved clock and data together");
	a_start_clock_low: assert property (p_start_clock_low)
		else $error("no clock low after start");
	a_stop_idle: assert property (p_stop_idle)
		else $error("bus not idle after stop");
	a_quiet_after_stop: assert property (p_quiet_after_stop)
		else $error("client drives data after stop");
	a_ack_ninth: assert property (p_ack_ninth)
		else $error("client drives data before ninth clock");
	a_low_phase: assert property (p_low_phase)
		else $error("clock low phase out of range");
	a_high_phase: assert property (p_high_phase)
		else $error("clock high phase too short");
endmodule

//--- sim/smbus_client_interface_bench.sv
`timescale 1ns/1ps
module smbus_client_interface_bench;
	import smci_pkg::*;
	localparam int QTR = QTR_CYC;
	localparam int SETTLE = 200;
	localparam int TMO = 3000;
	logic         clk_sys = 1'b0;
	logic         nrst = 1'b0;
	logic         timeout_en = 1'b0;
	logic [2:0]   strap_code = 3'h1;
	logic         alert_active = 1'b0;
	logic         cmd_valid = 1'b0;
	smci_cmd_type cmd_kind = SMCI_CMD_WRITE;
	logic [6:0]   cmd_addr = 7'h00;
	logic [7:0]   cmd_idx = 8'h00;
	logic [7:0]   cmd_data = 8'h00;
	logic         cmd_ready, rsp_done, rsp_nack, reg_wr_stb, ara_done, bus_ready, bus_ready_b;
	logic         ara_done_b;
	logic [7:0]   rsp_data, reg_wr_data, reg_ptr;
	logic [7:0]   regs [0:255];
	int           error_cnt = 0;
	int           comparisons = 0;
	int           wr_cnt = 0;
	int           ara_cnt = 0;
	smci_bus_if bus ();
	smci_bus_if bus_b ();
	// Ends under test, plus a second client driven by hand
	smci_client #(.SETTLE_CYCLES(SETTLE), .TIMEOUT_CYCLES(TMO)) i_smci_client (
		.clk_sys(clk_sys), .nrst(nrst), .clk_en(1'b1), .bus(bus.dev),
		.timeout_en(timeout_en), .strap_code(strap_code), .reg_wr_stb(reg_wr_stb),
		.reg_wr_data(reg_wr_data), .reg_ptr(reg_ptr), .reg_rd_data(regs[reg_ptr]),
		.alert_active(alert_active), .ara_done(ara_done), .bus_ready(bus_ready));
	smci_client #(.SETTLE_CYCLES(SETTLE), .TIMEOUT_CYCLES(TMO)) i_smci_client_b (
		.clk_sys(clk_sys), .nrst(nrst), .clk_en(1'b1), .bus(bus_b.dev),
		.timeout_en(timeout_en), .strap_code(strap_code), .reg_wr_stb(),
		.reg_wr_data(), .reg_ptr(), .reg_rd_data(8'h00),
		.alert_active(alert_active), .ara_done(ara_done_b), .bus_ready(bus_ready_b));
	smci_host #(.QTR_CYCLES(QTR), .SETTLE_CYCLES(SETTLE)) i_smci_host (
		.clk_sys(clk_sys), .nrst(nrst), .clk_en(1'b1), .bus(bus.host),
		.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_idx(cmd_idx),
		.cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_done(rsp_done),
		.rsp_nack(rsp_nack), .rsp_data(rsp_data));
	smci_assertions #(.QTR_CYCLES(QTR)) i_smci_assertions (
		.clk_sys(clk_sys), .nrst(nrst), .scl_host_oe(bus.scl_host_oe),
		.sda_host_oe(bus.sda_host_oe), .sda_dev_oe(bus.sda_dev_oe), .scl(bus.scl), .sda(bus.sda));
	// Clock
	always #5 clk_sys = ~clk_sys;
	// Register file model and event counts
	always @(posedge clk_sys) begin
		if (reg_wr_stb) begin
			regs[reg_ptr] <= reg_wr_data;
			wr_cnt <= wr_cnt + 1;
		end
		if (ara_done || ara_done_b) ara_cnt <= ara_cnt + 1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// One command through the host end, bounded waits
	task automatic run_cmd(input smci_cmd_type k, input logic [6:0] a, input logic [7:0] i, d);
		int n;
		n = 0;
		cmd_kind = k;
		cmd_addr = a;
		cmd_idx = i;
		cmd_data = d;
		cmd_valid = 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (cmd_ready !== 1'b1 && n < 20000);
		#1;
		cmd_valid = 1'b0;
		while (rsp_done !== 1'b1 && n < 20000) begin
			@(posedge clk_sys);
			n++;
		end
		#1;
		if (n >= 20000) begin
			error_cnt++;
			final_report;
		end
	endtask
	// Hand-driven host on the second bus, 160 ns bit period
	task automatic bb_bit(input logic b, output logic r);
		bus_b.sda_host_oe = ~b;
		tick(4);
		bus_b.scl_host_oe = 1'b0;
		tick(4);
		r = bus_b.sda;
		tick(4);
		bus_b.scl_host_oe = 1'b1;
		tick(4);
	endtask
	task automatic bb_start;
		bus_b.sda_host_oe = 1'b0;
		bus_b.scl_host_oe = 1'b0;
		tick(4);
		bus_b.sda_host_oe = 1'b1;
		tick(4);
		bus_b.scl_host_oe = 1'b1;
		tick(4);
	endtask
	task automatic bb_stop;
		bus_b.sda_host_oe = 1'b1;
		tick(4);
		bus_b.scl_host_oe = 1'b0;
		tick(4);
		bus_b.sda_host_oe = 1'b0;
		tick(4);
	endtask
	// Start, one byte, returns data level in the ninth clock
	task automatic bb_addr(input logic [7:0] v, output logic ack);
		logic r;
		bb_start;
		for (int i = 7; i >= 0; i--) bb_bit(v[i], r);
		bb_bit(1'b1, ack);
	endtask
	task automatic t_strap;
		logic [6:0] exp_addr [0:5] = '{7'h7C, 7'h5C, 7'h4C, 7'h6C, 7'h1C, 7'h3C};
		logic r;
		int n;
		for (int c = 2; c < 8; c++) begin
			nrst = 1'b0;
			strap_code = 3'(c % 6);
			tick(16);
			nrst = 1'b1;
			bb_addr({exp_addr[c % 6], 1'b0}, r);
			check(8'(r), 8'h01);
			bb_stop;
			n = 0;
			while (bus_ready_b !== 1'b1 && n < 1000) begin
				tick(1);
				n++;
			end
			if (n >= 1000) begin
				error_cnt++;
				final_report;
			end
			check(8'(bus_ready_b), 8'h01);
			bb_addr({exp_addr[c % 6], 1'b0}, r);
			check(8'(r), 8'h00);
			bb_stop;
			bb_addr({exp_addr[c % 6] ^ 7'h20, 1'b0}, r);
			check(8'(r), 8'h01);
			bb_stop;
		end
		$display("test strap done");
	endtask
	task automatic t_timeout;
		logic r;
		bb_addr({7'h5C, 1'b1}, r);
		check(8'(r), 8'h00);
		tick(20);
		check(8'(bus_b.sda), 8'h00);
		tick(TMO + 500);
		check(8'(bus_b.sda), 8'h00);
		timeout_en = 1'b1;
		tick(TMO + 100);
		check(8'(bus_b.sda), 8'h01);
		timeout_en = 1'b0;
		bb_stop;
		bb_addr({7'h5C, 1'b0}, r);
		check(8'(r), 8'h00);
		bb_stop;
		$display("test timeout done");
	endtask
	// Alert answer on the second bus, host forces a zero over the answer's first one
	task automatic t_arbit;
		logic r;
		int a;
		a = ara_cnt;
		alert_active = 1'b1;
		bb_addr({ARA_ADDR, 1'b1}, r);
		check(8'(r), 8'h00);
		bb_bit(1'b0, r);
		bb_bit(1'b1, r);
		check(8'(r), 8'h01);
		bb_stop;
		check(8'(ara_cnt - a), 8'h00);
		alert_active = 1'b0;
		$display("test arbitration done");
	endtask
	task automatic t_write_read;
		int w;
		w = wr_cnt;
		run_cmd(SMCI_CMD_WRITE, 7'h5C, 8'h11, 8'hC6);
		check(8'(rsp_nack), 8'h00);
		check(regs[8'h11], 8'hC6);
		check(reg_ptr, 8'h11);
		check(8'(wr_cnt - w), 8'h01);
		run_cmd(SMCI_CMD_READ, 7'h5C, 8'h11, 8'h00);
		check(8'(rsp_nack), 8'h00);
		check(rsp_data, 8'hC6);
		$display("test write read done");
	endtask
	task automatic t_send_recv;
		int w;
		w = wr_cnt;
		run_cmd(SMCI_CMD_SEND, 7'h5C, 8'hF0, 8'h00);
		check(reg_ptr, 8'hF0);
		check(8'(wr_cnt - w), 8'h00);
		repeat (2) begin
			run_cmd(SMCI_CMD_RECV, 7'h5C, 8'h00, 8'h00);
			check(rsp_data, 8'hCC);
			check(reg_ptr, 8'hF0);
		end
		$display("test send receive done");
	endtask
	task automatic t_bad;
		int w;
		w = wr_cnt;
		run_cmd(SMCI_CMD_WRITE, 7'h4C, 8'h11, 8'h5A);
		check(8'(rsp_nack), 8'h01);
		check(regs[8'h11], 8'hC6);
		check(8'(wr_cnt - w), 8'h00);
		$display("test bad address done");
	endtask
	task automatic t_ara;
		int a;
		a = ara_cnt;
		run_cmd(SMCI_CMD_ARA, ARA_ADDR, 8'h00, 8'h00);
		check(8'(rsp_nack), 8'h01);
		alert_active = 1'b1;
		run_cmd(SMCI_CMD_ARA, ARA_ADDR, 8'h00, 8'h00);
		check(8'(rsp_nack), 8'h00);
		check(rsp_data, 8'hB8);
		check(8'(ara_cnt - a), 8'h01);
		check(regs[8'h11], 8'hC6);
		alert_active = 1'b0;
		$display("test alert response done");
	endtask
	// Main sequence
	initial begin
		bus_b.scl_host_oe = 1'b0;
		bus_b.sda_host_oe = 1'b0;
		for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'h3C;
		t_strap;
		t_timeout;
		t_arbit;
		t_write_read;
		t_send_recv;
		t_bad;
		t_ara;
		final_report;
	end
endmodule
